// >>> core/bus_float_defines.svh
// Purpose : Constants for the bus float and address drive block
// Assumes : Clock is the double-rate input clock, 200 MHz
// Notes   : Functional notes follow
// Functional notes
// - Float tristates every output and bidirectional pin
// - Float request async active low, sampled rising
// - Float aborts current bus cycle unconditionally
// - Reset across release restores valid state
// - Ordinary I/O cycles drive upper sixteen low
// - Coprocessor cycles drive line 31 high
// - Coprocessor command F8, data FC addresses
// - Address lines float in hold or float
// - Address strobe floats in hold or float
`ifndef BUS_FLOAT_DEFINES_SVH
`define BUS_FLOAT_DEFINES_SVH

// ----------------------------------------------------------------
// Addresses and timing
// ----------------------------------------------------------------
`define COPRO_CMD_ADDR    32'h8000_00F8
`define COPRO_DATA_ADDR   32'h8000_00FC
`define IO_UPPER_ZERO     16'h0000
`define FLOAT_MIN_CLOCKS  5'h10
`define CYCLE_LEN_RESET   4'h0

`endif

// >>> core/bus_float_drive.sv
// Purpose : Float control and address drive for the processor bus
// Assumes : clk is the double-rate input clock; core logic is same clk
// Notes   : Float is left only through reset
`timescale 1ns/10ps
`default_nettype none
`include "bus_float_defines.svh"
module bus_float_drive
    import bus_float_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        float_request_n,
    input  wire logic        hold_req,
    input  wire logic        req_valid,
    input  wire bus_req_t    req,
    input  wire logic        ready_n,
    output logic [29:0]      word_address_lines_o,
    output logic [29:0]      word_address_lines_oe,
    output logic             address_strobe_n_o,
    output logic             address_strobe_n_oe,
    output logic             pins_oe,
    output logic             hold_ack,
    output logic             hold_ack_oe,
    output logic             cycle_busy,
    output logic             float_active,
    output logic             cycle_aborted
);
    logic       float_sync_n; // Synchronised float request
    logic       ready_s1_reg; // Ready sync stage one
    logic       ready_s2_reg; // Ready sync stage two
    logic       hold_s1_reg;  // Hold sync stage one
    logic       hold_s2_reg;  // Hold sync stage two
    logic       float_reg;    // Float mode latched
    logic       release_reg;  // Outputs released
    logic [29:0] addr_next;   // Address for new cycle

    // Cycle sequencer states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ADDR  = 3'b010,
        ST_WAIT  = 3'b100
    } cyc_state_t;
    cyc_state_t state_reg;
    logic       start_now;    // New cycle launched at this edge

    // True when a new cycle may be launched at this edge
    function automatic logic start_ok(input cyc_state_t st,
                                      input logic       valid,
                                      input logic       hold,
                                      input logic       flt,
                                      input logic       flt_sync_n);
        return (st == ST_IDLE) && valid && !hold && !flt && flt_sync_n;
    endfunction

    // Launch decision shared by sequencer and address register
    always_comb begin
        start_now = start_ok(state_reg, req_valid, hold_s2_reg,
                             float_reg, float_sync_n);
    end

    // ----------------------------------------------------------------
    // Address formation
    // ----------------------------------------------------------------
    // Maps a request to the word address lines
    function automatic logic [29:0] form_addr(input bus_req_t r);
        logic [31:0] full;
        full = 32'h0000_0000;
        case (r.kind)
            CYC_MEM:   full = {r.word_addr, 2'b00};
            CYC_IO:    full = {`IO_UPPER_ZERO, r.word_addr[13:0], 2'b00};
            CYC_COPRO: full = r.copro_data ? `COPRO_DATA_ADDR
                                           : `COPRO_CMD_ADDR;
            default:   full = {r.word_addr, 2'b00};
        endcase
        return full[31:2];
    endfunction

    always_comb begin
        addr_next = form_addr(req);
    end

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    // float request sampled on rising edge
    float_sync u_float_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .async_n (float_request_n),
        .sync_n  (float_sync_n)
    );

    // Ready and hold come from board pins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ready_s1_reg <= 1'b1;
            ready_s2_reg <= 1'b1;
            hold_s1_reg  <= 1'b0;
            hold_s2_reg  <= 1'b0;
        end else begin
            ready_s1_reg <= ready_n;
            ready_s2_reg <= ready_s1_reg;
            hold_s1_reg  <= hold_req;
            hold_s2_reg  <= hold_s1_reg;
        end
    end

    // ----------------------------------------------------------------
    // Float mode
    // ----------------------------------------------------------------
    // only reset clears float mode
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            float_reg <= 1'b0;
        end else if (!float_sync_n) begin
            float_reg <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Cycle sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg     <= ST_IDLE;
            cycle_aborted <= 1'b0;
        end else begin
            cycle_aborted <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (start_now) begin
                        state_reg <= ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    state_reg <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (!ready_s2_reg) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
            if (!float_sync_n && state_reg != ST_IDLE) begin
                state_reg     <= ST_IDLE;
                cycle_aborted <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Address and strobe values
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            word_address_lines_o <= 30'h0000_0000;
            address_strobe_n_o   <= 1'b1;
            cycle_busy           <= 1'b0;
        end else begin
            address_strobe_n_o <= 1'b1;
            if (start_now) begin
                word_address_lines_o <= addr_next;
                address_strobe_n_o   <= 1'b0;
            end
            cycle_busy <= (state_reg != ST_IDLE) && float_sync_n;
        end
    end

    // ----------------------------------------------------------------
    // Hold acknowledge and output enables
    // ----------------------------------------------------------------
    always_comb begin
        release_reg = float_reg || !float_sync_n;
    end

    // address and strobe enables drop in hold or float; pins_oe and hold_ack_oe in float only
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hold_ack              <= 1'b0;
            hold_ack_oe           <= 1'b1;
            pins_oe               <= 1'b1;
            word_address_lines_oe <= {30{1'b1}};
            address_strobe_n_oe   <= 1'b1;
            float_active          <= 1'b0;
        end else begin
            hold_ack <= hold_s2_reg && state_reg == ST_IDLE && !release_reg;
            hold_ack_oe           <= !release_reg;
            pins_oe               <= !release_reg;
            word_address_lines_oe <= {30{!release_reg && !hold_ack}};
            address_strobe_n_oe   <= !release_reg && !hold_ack;
            float_active          <= release_reg;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    float_holds_a: assert property (@(posedge clk) disable iff (sys_rst)
        float_active |=> !pins_oe && !address_strobe_n_oe)
        else $error("Pins driven while floating");
    float_sticky_a: assert property (@(posedge clk) disable iff (sys_rst)
        float_reg |=> float_reg)
        else $error("Float left without reset");
    abort_cycle_a: assert property (@(posedge clk) disable iff (sys_rst)
        (!float_sync_n && state_reg != ST_IDLE) |=> state_reg == ST_IDLE)
        else $error("Cycle not aborted on float");
    addr_float_a: assert property (@(posedge clk) disable iff (sys_rst)
        (hold_ack || float_active) |=> word_address_lines_oe == 30'h0)
        else $error("Address driven in hold or float");
    io_upper_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == ST_IDLE && req_valid && req.kind == CYC_IO &&
         !hold_s2_reg && !float_reg && float_sync_n)
        |=> word_address_lines_o[29:14] == 16'h0000)
        else $error("I/O upper address not low");
    copro_addr_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == ST_IDLE && req_valid && req.kind == CYC_COPRO &&
         !hold_s2_reg && !float_reg && float_sync_n)
        |=> word_address_lines_o[29] && word_address_lines_o[28:14] == 0)
        else $error("Coprocessor address wrong");
    strobe_float_a: assert property (@(posedge clk) disable iff (sys_rst)
        float_active |-> ##1 !address_strobe_n_oe [*2])
        else $error("Strobe driven while floating");
    sync_delay_a: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(float_sync_n) |=> float_reg)
        else $error("Float not entered after request");
endmodule
`default_nettype wire

// >>> core/bus_float_pkg.sv
// Purpose : Types for the bus float and address drive block
// Assumes : Constants live in the defines header
// Notes   : Cycle kinds and a request carrier
package bus_float_pkg;

    // Kind of bus cycle requested by the core
    typedef enum logic [1:0] {
        CYC_MEM   = 2'b00,
        CYC_IO    = 2'b01,
        CYC_COPRO = 2'b10
    } cycle_kind_t;

    // Bus cycle request from the core
    typedef struct packed {
        cycle_kind_t kind;       // Memory, I/O or coprocessor
        logic        copro_data; // Coprocessor data, else command
        logic [29:0] word_addr;  // Word address from core
    } bus_req_t;

endpackage

// >>> core/float_sync.sv
// Purpose : Two-flop synchroniser for the float request
// Assumes : Input is asynchronous to clk
// Notes   : Reset value is the inactive (high) level
`timescale 1ns/10ps
`default_nettype none
module float_sync (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic async_n,
    output logic      sync_n
);
    logic meta_reg; // First stage, read only by second

    // ----------------------------------------------------------------
    // Synchroniser stages
    // ----------------------------------------------------------------
    // two flop chain
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_reg <= 1'b1;
            sync_n   <= 1'b1;
        end else begin
            meta_reg <= async_n;
            sync_n   <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// >>> tb/bus_float_and_address_drive_tb_top.sv
// Purpose : Self-checking bench for float control and address drive
// Assumes : 200 MHz clock, inputs driven 1 ns after the rising edge
// Notes   : Address kinds in a table, hold and float by hand
`timescale 1ns/10ps
`default_nettype none
module bus_float_and_address_drive_tb_top;
    import bus_float_pkg::*;
    typedef struct packed {
        cycle_kind_t kind;  // Cycle kind
        logic        dsel;  // Coprocessor data select
        logic [29:0] win;   // Word address given
        logic [29:0] wexp;  // Word address expected on the lines
    } row_t;

    logic        clk, sys_rst, float_request_n, hold_req, req_valid;
    logic        stall, ready_n, strobe_n, strobe_oe, pins_oe;
    logic        hold_ack, hold_ack_oe, cycle_busy, float_active;
    logic        cycle_aborted, seen;
    bus_req_t    req;
    logic [29:0] addr_o, addr_oe;
    int          mismatches, checks_done;
    row_t        rows [6] = '{
        '{CYC_MEM,   1'b0, 30'h3fff_ffff, 30'h3fff_ffff},
        '{CYC_MEM,   1'b0, 30'h0000_0000, 30'h0000_0000},
        '{CYC_IO,    1'b0, 30'h3fff_ffff, 30'h0000_3fff},
        '{CYC_IO,    1'b1, 30'h2aaa_5555, 30'h0000_1555},
        '{CYC_COPRO, 1'b0, 30'h3fff_ffff, 30'h2000_003e},
        '{CYC_COPRO, 1'b1, 30'h0000_0000, 30'h2000_003f}};

    bus_float_drive u_dut (.clk(clk), .sys_rst(sys_rst),
        .float_request_n(float_request_n), .hold_req(hold_req),
        .req_valid(req_valid), .req(req), .ready_n(ready_n),
        .word_address_lines_o(addr_o), .word_address_lines_oe(addr_oe),
        .address_strobe_n_o(strobe_n), .address_strobe_n_oe(strobe_oe),
        .pins_oe(pins_oe), .hold_ack(hold_ack), .hold_ack_oe(hold_ack_oe),
        .cycle_busy(cycle_busy), .float_active(float_active),
        .cycle_aborted(cycle_aborted));
    bus_ready_model u_far (.clk(clk), .sys_rst(sys_rst),
        .address_strobe_n_o(strobe_n), .address_strobe_n_oe(strobe_oe),
        .cycle_busy(cycle_busy), .stall(stall), .ready_n(ready_n));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Verdict and end of run
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic go(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check_vec(input logic [29:0] got, input logic [29:0] e);
        checks_done++;
        if (got !== e) begin
            mismatches++;
            $display("ERROR %0t vector %h expected %h", $time, got, e);
        end
    endtask

    task automatic check_bit(input logic got, input logic e);
        checks_done++;
        if (got !== e) begin
            mismatches++;
            $display("ERROR %0t flag %b expected %b", $time, got, e);
        end
    endtask

    // Bounded wait: 0 strobe low, 1 idle, 2 hold acknowledged
    task automatic wait_until(input int sel);
        for (int i = 0; i < 40; i++) begin
            if ((sel == 0 && strobe_n === 1'b0) ||
                (sel == 1 && cycle_busy === 1'b0) ||
                (sel == 2 && hold_ack === 1'b1)) begin
                return;
            end
            go(1);
        end
        mismatches++;
        $display("ERROR %0t wait %0d timed out", $time, sel);
        conclude();
    endtask

    // One bus cycle, address checked during the strobe; left unfinished when stall is set
    task automatic run_cycle(input row_t r);
        req = {r.kind, r.dsel, r.win};
        req_valid = 1'b1;
        wait_until(0);
        check_vec(addr_o, r.wexp);
        check_vec(addr_oe, 30'h3fff_ffff);
        req_valid = 1'b0;
        if (!stall) begin
            go(1);
            check_bit(cycle_busy, 1'b1);
            wait_until(1);
            go(2);
        end
    endtask

    initial begin
        sys_rst = 1'b1;
        float_request_n = 1'b1;
        hold_req = 1'b0;
        req_valid = 1'b0;
        stall = 1'b0;
        req = '0;
        mismatches = 0;
        checks_done = 0;
        go(20);
        check_bit(strobe_n, 1'b1);
        check_vec(addr_o, 30'h0000_0000);
        check_vec(addr_oe, 30'h3fff_ffff);
        check_bit(float_active, 1'b0);
        check_bit(hold_ack, 1'b0);
        $display("reset test done");
        sys_rst = 1'b0;
        go(1);
        foreach (rows[i]) begin
            run_cycle(rows[i]);
            $display("address row %0d done", i);
        end
        hold_req = 1'b1;
        wait_until(2);
        go(2);
        check_vec(addr_oe, 30'h0000_0000);
        check_bit(strobe_oe, 1'b0);
        check_bit(hold_ack, 1'b1);
        hold_req = 1'b0;
        go(6);
        check_vec(addr_oe, 30'h3fff_ffff);
        check_bit(hold_ack, 1'b0);
        $display("hold test done");
        stall = 1'b1;
        run_cycle(rows[0]);
        float_request_n = 1'b0;
        seen = 1'b0;
        for (int i = 0; i < 16; i++) begin
            go(1);
            seen |= (cycle_aborted === 1'b1);
        end
        check_bit(seen, 1'b1);
        check_bit(cycle_busy, 1'b0);
        check_bit(float_active, 1'b1);
        check_bit(pins_oe, 1'b0);
        check_bit(hold_ack_oe, 1'b0);
        check_vec(addr_oe, 30'h0000_0000);
        check_bit(strobe_oe, 1'b0);
        $display("float test done");
        sys_rst = 1'b1;
        go(2);
        float_request_n = 1'b1;
        go(4);
        sys_rst = 1'b0;
        stall = 1'b0;
        go(1);
        check_bit(float_active, 1'b0);
        check_bit(pins_oe, 1'b1);
        check_vec(addr_oe, 30'h3fff_ffff);
        check_bit(strobe_oe, 1'b1);
        run_cycle(rows[4]);
        $display("float exit test done");
        conclude();
    end
endmodule
`default_nettype wire

// >>> tb/bus_ready_model.sv
// Purpose : Far-side bus logic answering cycles with ready
// Assumes : Strobe low means a new cycle was started
// Notes   : Stall input holds ready back to model a slow target
`timescale 1ns/10ps
`default_nettype none
module bus_ready_model (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic address_strobe_n_o,
    input  wire logic address_strobe_n_oe,
    input  wire logic cycle_busy,
    input  wire logic stall,
    output logic      ready_n
);
    logic pending;  // A started cycle still awaits its ready

    // Answer after the strobe; pull-up level once the cycle is over
    always @(posedge clk) begin
        #1;
        if (sys_rst === 1'b1) begin
            pending = 1'b0;
        end else if (address_strobe_n_oe === 1'b1 &&
                     address_strobe_n_o === 1'b0) begin
            pending = 1'b1;
        end else if (cycle_busy === 1'b0) begin
            pending = 1'b0;
        end
        ready_n = !(pending && !stall);
    end
endmodule
`default_nettype wire
